// ### common/seq_side_regs.svh
// What this block does
// R1 - A raise-flag vector sets every handshake flag in its list and no other.
// R2 - A lower-flag vector clears every handshake flag in its list that the same vector does not raise.
// R3 - The pattern names each handshake flag 0 to 3 at most once per list.
// R4 - The run-time program sees the handshake flags while the sequencer runs.
// R5 - A store-value vector writes a 16-bit immediate into one of 16 registers.
// R6 - The run-time program can read all sixteen value registers.
// R7 - An assert-event vector drives listed events high until a later deassert.
// R8 - A deassert-event vector drives listed events low, a cycle late if it strobes them and not if it asserts them; others untouched.
// R9 - A strobe-event vector pulses each listed event high then low by itself, unless an assert holds that event high.
// R10 - The pattern names each event output 0 to 3 at most once per list.
// R11 - Software routes each event output onto backplane trigger lines.
// R12 - A rearm vector clears each listed trigger latch and re-enables capture.
// R13 - The pattern should rearm trigger latches before branching on them.
// R14 - The pattern names each trigger latch 0 to 3 at most once per list.
// R15 - Every action of a vector takes effect in the cycle that executes it; a deassert of an event that the same vector strobes drops it a cycle later.
// R16 - Reset clears flags, events, trigger latches and value registers.
`ifndef SEQ_SIDE_REGS_SVH
`define SEQ_SIDE_REGS_SVH

// ===========================================
// Register byte offsets
`define OFS_FLAGS      8'h00
`define OFS_EVENTS     8'h04
`define OFS_TRIGGERS   8'h08
`define OFS_ROUTE      8'h0C
`define OFS_STATUS     8'h10
`define OFS_MASK       8'h14
`define OFS_VALUE_BASE 8'h40

// ===========================================
// Field positions
`define TRIG_ARMED_LSB 4
`define ROUTE_FIELD_W  3
`define ROUTE_EN_BIT   2
`define STAT_STORE_BIT 4
`define STAT_FLAG_BIT  5
`define STAT_W         6

// ===========================================
// Reset values
`define FLAGS_RST  4'h0
`define EVENTS_RST 4'h0
`define LATCH_RST  4'h0
`define ARMED_RST  4'hF
`define ROUTE_RST  12'h000
`define STATUS_RST 6'h00
`define MASK_RST   6'h00
`define VALUE_RST  16'h0000

// ===========================================
// Bus answer timing
`define BUS_WAIT_CYCLES 1

`endif

// ### common/seq_side_pkg.sv
package seq_side_pkg;

	// ===========================================
	// Actions carried by one executing vector
	typedef struct packed {
		logic [3:0]  raise_flags;
		logic [3:0]  lower_flags;
		logic        store_en;
		logic [3:0]  store_sel;
		logic [15:0] store_value;
		logic [3:0]  ev_assert;
		logic [3:0]  ev_deassert;
		logic [3:0]  ev_strobe;
		logic [3:0]  rearm;
	} vector_ops_t;

	// ===========================================
	// Bus slave phase
	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} bus_phase_t;

endpackage

// ### src/seq_side_effects.sv
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "seq_side_regs.svh"

module seq_side_effects #(
	parameter int NUM_LINES = 4
) (
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic                      vec_valid,
	input  wire seq_side_pkg::vector_ops_t vec_ops,
	input  wire logic [3:0]                trig_in,
	input  wire logic [7:0]                address,
	input  wire logic                      read,
	input  wire logic                      write,
	input  wire logic [31:0]               writedata,
	output logic [31:0]                    readdata,
	output logic                           waitrequest,
	output logic [3:0]                     handshake_flag,
	output logic [3:0]                     event_output,
	output logic [3:0]                     trigger_latch,
	output logic [NUM_LINES-1:0]           backplane_line,
	output logic                           irq
);

	// ===========================================
	// Elaboration check
	if (NUM_LINES < 1 || NUM_LINES > 4) begin : g_bad_lines
		$error("NUM_LINES must lie between 1 and 4");
	end

	// ===========================================
	// Declarations
	seq_side_pkg::bus_phase_t phase_ff;
	seq_side_pkg::bus_phase_t nxt_phase;
	logic [31:0] readdata_ff;
	logic [31:0] nxt_readdata;
	logic        wait_ff;
	logic        nxt_wait;
	logic        wr_take;
	logic [3:0]  flags_ff;
	logic [3:0]  nxt_flags;
	logic [3:0]  hold_ff;
	logic [3:0]  nxt_hold;
	logic [3:0]  event_ff;
	logic [3:0]  nxt_event;
	logic [15:0] value_ff [16];
	logic [15:0] nxt_value [16];
	logic [3:0]  sync1_ff;
	logic [3:0]  sync2_ff;
	logic [3:0]  sync3_ff;
	logic [3:0]  level_ff;
	logic [3:0]  nxt_level;
	logic [3:0]  rise;
	logic [3:0]  latch_ff;
	logic [3:0]  nxt_latch;
	logic [3:0]  armed_ff;
	logic [3:0]  nxt_armed;
	logic [11:0] route_ff;
	logic [11:0] nxt_route;
	logic [NUM_LINES-1:0] line_ff;
	logic [NUM_LINES-1:0] nxt_line;
	logic [`STAT_W-1:0] status_ff;
	logic [`STAT_W-1:0] nxt_status;
	logic [`STAT_W-1:0] mask_ff;
	logic [`STAT_W-1:0] nxt_mask;
	logic [`STAT_W-1:0] stat_set;
	logic        irq_ff;
	logic        nxt_irq;

	assign readdata       = readdata_ff;
	assign waitrequest    = wait_ff;
	assign handshake_flag = flags_ff;
	assign event_output   = event_ff;
	assign trigger_latch  = latch_ff;
	assign backplane_line = line_ff;
	assign irq            = irq_ff;

	// ===========================================
	// Avalon slave: one wait cycle, then answer
	assign wr_take = write && !wait_ff;

	always_comb begin
		nxt_phase    = phase_ff;
		nxt_wait     = 1'b1;
		nxt_readdata = readdata_ff;
		unique case (phase_ff)
			seq_side_pkg::BUS_IDLE: begin
				if (read || write) begin
					nxt_phase = seq_side_pkg::BUS_ANSWER;
					nxt_wait  = 1'b0;
					nxt_readdata = 32'h0000_0000;
					// R4 flags visible
					if (address == `OFS_FLAGS)
						nxt_readdata[3:0] = flags_ff;
					if (address == `OFS_EVENTS)
						nxt_readdata[3:0] = event_ff;
					if (address == `OFS_TRIGGERS)
						nxt_readdata[7:0] = {armed_ff, latch_ff};
					if (address == `OFS_ROUTE)
						nxt_readdata[11:0] = route_ff;
					if (address == `OFS_STATUS)
						nxt_readdata[`STAT_W-1:0] = status_ff;
					if (address == `OFS_MASK)
						nxt_readdata[`STAT_W-1:0] = mask_ff;
					// R6 value readback
					if ((address & 8'hC3) == `OFS_VALUE_BASE)
						nxt_readdata[15:0] = value_ff[address[5:2]];
				end
			end
			seq_side_pkg::BUS_ANSWER: begin
				nxt_phase = seq_side_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phase_ff    <= seq_side_pkg::BUS_IDLE;
			wait_ff     <= 1'b1;
			readdata_ff <= 32'h0000_0000;
		end else begin
			phase_ff    <= nxt_phase;
			wait_ff     <= nxt_wait;
			readdata_ff <= nxt_readdata;
		end
	end

	// ===========================================
	// Handshake flags and value registers
	always_comb begin
		nxt_flags = flags_ff;
		if (wr_take && address == `OFS_FLAGS)
			nxt_flags = writedata[3:0];
		if (vec_valid) begin
			// R2 lower listed flags
			nxt_flags = nxt_flags & ~vec_ops.lower_flags;
			// R1 raise listed flags
			nxt_flags = nxt_flags | vec_ops.raise_flags;
		end
		for (int i = 0; i < 16; i++) begin
			nxt_value[i] = value_ff[i];
		end
		// R5 store immediate
		if (vec_valid && vec_ops.store_en)
			nxt_value[vec_ops.store_sel] = vec_ops.store_value;
	end

	// R15 same-cycle effect
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// R16 cleared state
			flags_ff <= `FLAGS_RST;
			for (int i = 0; i < 16; i++) begin
				value_ff[i] <= `VALUE_RST;
			end
		end else begin
			flags_ff <= nxt_flags;
			for (int i = 0; i < 16; i++) begin
				value_ff[i] <= nxt_value[i];
			end
		end
	end

	// ===========================================
	// Event outputs and backplane routing
	always_comb begin
		nxt_hold = hold_ff;
		if (vec_valid) begin
			// R8 deassert listed
			nxt_hold = nxt_hold & ~vec_ops.ev_deassert;
			// R7 assert and hold
			nxt_hold = nxt_hold | vec_ops.ev_assert;
		end
		// R9 one-cycle strobe
		nxt_event = nxt_hold;
		if (vec_valid)
			nxt_event = nxt_hold | vec_ops.ev_strobe;
		nxt_route = route_ff;
		if (wr_take && address == `OFS_ROUTE)
			nxt_route = writedata[11:0];
	end

	// Lines follow next event so they stay aligned with event_output
	for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
		localparam int B = l * `ROUTE_FIELD_W;
		// R11 software routing
		assign nxt_line[l] = route_ff[B + `ROUTE_EN_BIT] &&
			nxt_event[route_ff[B +: 2]];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hold_ff  <= `EVENTS_RST;
			event_ff <= `EVENTS_RST;
			route_ff <= `ROUTE_RST;
			line_ff  <= '0;
		end else begin
			hold_ff  <= nxt_hold;
			event_ff <= nxt_event;
			route_ff <= nxt_route;
			line_ff  <= nxt_line;
		end
	end

	// ===========================================
	// Trigger inputs: three-stage sync, latch
	// Level accepted only when stages two and three agree
	always_comb begin
		nxt_level = level_ff;
		for (int i = 0; i < 4; i++) begin
			if (sync2_ff[i] == sync3_ff[i])
				nxt_level[i] = sync3_ff[i];
		end
		rise      = nxt_level & ~level_ff;
		nxt_latch = latch_ff | (armed_ff & rise);
		nxt_armed = armed_ff & ~rise;
		if (vec_valid) begin
			// R12 rearm listed
			nxt_latch = nxt_latch & ~vec_ops.rearm;
			nxt_armed = nxt_armed | vec_ops.rearm;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
			sync3_ff <= 4'h0;
			level_ff <= 4'h0;
			latch_ff <= `LATCH_RST;
			armed_ff <= `ARMED_RST;
		end else begin
			sync1_ff <= trig_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			level_ff <= nxt_level;
			latch_ff <= nxt_latch;
			armed_ff <= nxt_armed;
		end
	end

	// ===========================================
	// Interrupt status, write one to clear
	always_comb begin
		stat_set = '0;
		stat_set[3:0] = nxt_latch & ~latch_ff;
		stat_set[`STAT_STORE_BIT] = vec_valid && vec_ops.store_en;
		stat_set[`STAT_FLAG_BIT]  = nxt_flags != flags_ff;
		nxt_status = status_ff;
		if (wr_take && address == `OFS_STATUS)
			nxt_status = status_ff & ~writedata[`STAT_W-1:0];
		// Set beats a clear in the same cycle
		nxt_status = nxt_status | stat_set;
		nxt_mask = mask_ff;
		if (wr_take && address == `OFS_MASK)
			nxt_mask = writedata[`STAT_W-1:0];
		nxt_irq = |(nxt_status & nxt_mask);
	end


	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_ff <= `STATUS_RST;
			mask_ff   <= `MASK_RST;
			irq_ff    <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			mask_ff   <= nxt_mask;
			irq_ff    <= nxt_irq;
		end
	end

	// ===========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_pulse_high;
		event_ff[0] ##1 !event_ff[0];
	endsequence

	sequence s_answer;
		##[1:2] !wait_ff;
	endsequence

	chk_raise_flags: assert property ( // R1
		vec_valid && vec_ops.lower_flags == 4'h0 |=>
		(flags_ff & $past(vec_ops.raise_flags)) ==
		$past(vec_ops.raise_flags))
		else $error("raised flag not set");

	chk_lower_flags: assert property ( // R2
		vec_valid && vec_ops.raise_flags == 4'h0 |=>
		(flags_ff & $past(vec_ops.lower_flags)) == 4'h0)
		else $error("lowered flag still set");

	chk_value_store: assert property ( // R5
		vec_valid && vec_ops.store_en |=>
		value_ff[$past(vec_ops.store_sel)] == $past(vec_ops.store_value))
		else $error("value register not stored");

	chk_event_hold: assert property ( // R7
		event_ff[0] && hold_ff[0] &&
		!(vec_valid && vec_ops.ev_deassert[0]) |=> event_ff[0])
		else $error("held event dropped");

	chk_event_clear: assert property ( // R8
		vec_valid && vec_ops.ev_deassert[1] && !vec_ops.ev_assert[1] &&
		!vec_ops.ev_strobe[1] |=> !event_ff[1])
		else $error("deasserted event still high");

	chk_strobe_pulse: assert property ( // R9
		vec_valid && vec_ops.ev_strobe[0] && !vec_ops.ev_assert[0] &&
		!hold_ff[0] ##1 !vec_valid |-> s_pulse_high)
		else $error("strobe pulse malformed");

	chk_rearm_latch: assert property ( // R12
		vec_valid && vec_ops.rearm[2] |=> !latch_ff[2] && armed_ff[2])
		else $error("rearmed latch not cleared");

	chk_bus_answer: assert property (
		(read || write) && phase_ff == seq_side_pkg::BUS_IDLE |-> s_answer)
		else $error("no bus answer");

	chk_irq_level: assert property (
		irq_ff == |(status_ff & mask_ff))
		else $error("irq level mismatch");

	chk_answer_once: assert property (
		!wait_ff |=> wait_ff)
		else $error("waitrequest low too long");

	chk_store_sets: assert property ( // R5
		vec_valid && vec_ops.store_en |=> status_ff[`STAT_STORE_BIT])
		else $error("store status not set");

	chk_status_sticky: assert property (
		status_ff[`STAT_STORE_BIT] &&
		!(wr_take && address == `OFS_STATUS &&
		writedata[`STAT_STORE_BIT]) |=> status_ff[`STAT_STORE_BIT])
		else $error("status bit lost");

	chk_latch_capture: assert property ( // R12
		armed_ff[1] && rise[1] &&
		!(vec_valid && vec_ops.rearm[1]) |=>
		latch_ff[1] && !armed_ff[1])
		else $error("armed trigger not captured");

	chk_line_follow: assert property ( // R11
		$stable(route_ff) |->
		line_ff[0] ==
		(route_ff[`ROUTE_EN_BIT] && event_ff[route_ff[1:0]]))
		else $error("backplane line off its event");

endmodule // seq_side_effects

// ### dv/trig_source.sv
`timescale 1ns/1ps

// ===========================================
// Far-side trigger source
module trig_source (
	input  wire logic       clk,
	input  wire logic [3:0] fire,
	output logic      [3:0] trig
);
	logic [3:0] held;

	initial trig = 4'h0;

	// Off-edge pin change, as real async triggers arrive
	// Request copied at the edge: the bench drops it right after
	always @(posedge clk) begin
		if (|fire) begin
			held = fire;
			#37 trig = trig | held;
			repeat (6) @(posedge clk);
			#37 trig = trig & ~held;
		end
	end
endmodule // trig_source

// ### dv/sequencer_flags_events_triggers_test.sv
`timescale 1ns/1ps
`include "seq_side_regs.svh"

module sequencer_flags_events_triggers_test;
	logic                      clk, reset, vec_valid, read, write;
	logic                      waitrequest, irq;
	seq_side_pkg::vector_ops_t vec_ops;
	logic [3:0]                trig_in, fire, handshake_flag;
	logic [3:0]                event_output, trigger_latch, backplane_line;
	logic [7:0]                address;
	logic [31:0]               writedata, readdata, rd;
	int                        fails, n_checks;

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		vec_valid = 1'b0;
		vec_ops = '0;
		fire = 4'h0;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		fails = 0;
		n_checks = 0;
	end
	always #50 clk = ~clk;

	seq_side_effects i_seq_side_effects (.clk(clk), .reset(reset),
		.vec_valid(vec_valid), .vec_ops(vec_ops), .trig_in(trig_in),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .handshake_flag(handshake_flag),
		.event_output(event_output), .trigger_latch(trigger_latch),
		.backplane_line(backplane_line), .irq(irq));
	trig_source i_trig_source (.clk(clk), .fire(fire), .trig(trig_in));

	// ===========================================
	// Shared helpers
	function automatic logic [31:0] outs();
		return {15'h0, irq, handshake_flag, event_output, trigger_latch,
			backplane_line};
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50) begin
			fails++;
			wrap_up();
		end
	endtask

	task automatic vec(input logic [3:0] rf, lf, ea, ed, es, rm,
			input logic st, input logic [3:0] sel, input logic [15:0] v);
		@(posedge clk);
		vec_valid <= 1'b1;
		vec_ops <= {rf, lf, st, sel, v, ea, ed, es, rm};
		@(posedge clk);
		vec_valid <= 1'b0;
		#1;
	endtask

	task automatic pulse_wait(input logic [3:0] m);
		int n;
		n = 0;
		@(posedge clk);
		fire <= m;
		@(posedge clk);
		fire <= 4'h0;
		while (trigger_latch !== m && n < 20) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		#1;
		if (n >= 20) begin
			fails++;
			wrap_up();
		end
	endtask

	// ===========================================
	// Scenarios
	task automatic t_reset();
		chk("outputs", 32'h0, outs());
		bus(1'b0, `OFS_TRIGGERS, 32'h0);
		chk("trig reg", 32'hF0, rd);
		bus(1'b0, `OFS_VALUE_BASE + 8'h3C, 32'h0);
		chk("value 15", 32'h0, rd);
		bus(1'b0, 8'h30, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask

	task automatic t_flags();
		vec(4'h9, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0, 16'h0);
		chk("outputs", 32'h9000, outs());
		vec(4'h6, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0, 16'h0);
		chk("outputs", 32'h7000, outs());
		vec(4'h0, 4'h5, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0, 16'h0);
		chk("outputs", 32'h2000, outs());
		bus(1'b0, `OFS_FLAGS, 32'h0);
		chk("flags reg", 32'h2, rd);
		bus(1'b1, `OFS_FLAGS, 32'hD);
		bus(1'b0, `OFS_FLAGS, 32'h0);
		chk("flags written", 32'hD, rd);
		bus(1'b1, `OFS_FLAGS, 32'h2);
	endtask

	task automatic t_values();
		vec(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 4'h5, 16'hB1FA);
		vec(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 4'hF, 16'hFFFF);
		bus(1'b0, `OFS_VALUE_BASE + 8'h14, 32'h0);
		chk("value 5", 32'hB1FA, rd);
		bus(1'b0, `OFS_VALUE_BASE + 8'h3C, 32'h0);
		chk("value 15", 32'hFFFF, rd);
		bus(1'b0, `OFS_VALUE_BASE, 32'h0);
		chk("value 0", 32'h0, rd);
		bus(1'b1, `OFS_VALUE_BASE + 8'h14, 32'h1234);
		bus(1'b0, `OFS_VALUE_BASE + 8'h14, 32'h0);
		chk("value 5 ro", 32'hB1FA, rd);
	endtask

	task automatic t_events();
		// Line 0 follows event 2, line 1 event 0, lines 2-3 off
		bus(1'b1, `OFS_ROUTE, 32'h26);
		bus(1'b0, `OFS_ROUTE, 32'h0);
		chk("route reg", 32'h26, rd);
		vec(4'h0, 4'h0, 4'h5, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0, 16'h0);
		chk("outputs", 32'h2503, outs());
		repeat (3) @(posedge clk);
		#1;
		chk("outputs", 32'h2503, outs());
		vec(4'h0, 4'h0, 4'h0, 4'h1, 4'h8, 4'h0, 1'b0, 4'h0, 16'h0);
		chk("outputs", 32'h2C01, outs());
		@(posedge clk);
		#1;
		chk("outputs", 32'h2401, outs());
		bus(1'b0, `OFS_EVENTS, 32'h0);
		chk("events reg", 32'h4, rd);
	endtask

	task automatic t_triggers();
		bus(1'b1, `OFS_MASK, 32'h30);
		repeat (2) @(posedge clk);
		#1;
		chk("irq on", 32'h12401, outs());
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk("status reg", 32'h30, rd);
		bus(1'b0, `OFS_MASK, 32'h0);
		chk("mask reg", 32'h30, rd);
		bus(1'b1, `OFS_STATUS, 32'h30);
		bus(1'b1, `OFS_MASK, 32'h0F);
		repeat (2) @(posedge clk);
		#1;
		chk("irq off", 32'h02401, outs());
		pulse_wait(4'h2);
		chk("outputs", 32'h12421, outs());
		bus(1'b0, `OFS_TRIGGERS, 32'h0);
		chk("trig reg", 32'hD2, rd);
		// Rearm before any branch on the latch, one name per bit
		vec(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 1'b0, 4'h0, 16'h0);
		chk("outputs", 32'h12401, outs());
		bus(1'b0, `OFS_TRIGGERS, 32'h0);
		chk("trig reg", 32'hF0, rd);
		repeat (10) @(posedge clk);
		pulse_wait(4'h2);
		chk("recapture", 32'h2, {28'h0, trigger_latch});
		repeat (8) @(posedge clk);
		bus(1'b1, `OFS_STATUS, 32'h3F);
		repeat (2) @(posedge clk);
		#1;
		chk("irq clear", 32'h02421, outs());
	endtask

	task automatic t_mid_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_reset();
	endtask

	// ===========================================
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_flags();
		t_values();
		t_events();
		t_triggers();
		t_mid_reset();
		wrap_up();
	end
endmodule // sequencer_flags_events_triggers_test
